// ==== pkg/lds_regs.svh ====
`ifndef LDS_REGS_SVH
`define LDS_REGS_SVH

// ****************************************************************
// command byte codes that the slave acts on itself
// ****************************************************************
`define LDS_CMD_SHUTDOWN 8'h0c
`define LDS_CMD_FEATURE 8'h0e
`define LDS_CMD_SELF_ADDR 8'h2d
// command bytes with these top bits clear, except shutdown and feature, reach the mirror array
`define LDS_CMD_PAGE_MSB 7
`define LDS_CMD_PAGE_LSB 5
`define LDS_CMD_PAGE_ZERO 3'h0
`define LDS_CMD_IDX_MSB 4

// ****************************************************************
// shutdown register fields and codes
// ****************************************************************
`define LDS_KEEP_FEATURE_BIT 7
`define LDS_NORMAL_OPERATION_BIT 0
// value written internally when the hardware shutdown pin is low
`define LDS_SD_PIN_CODE 8'h00
`define LDS_SD_RESET 8'h00
`define LDS_FEATURE_RESET 8'h00
`define LDS_REG_RESET 8'h00

// ****************************************************************
// slave address layout
// ****************************************************************
// fixed upper five bits of the seven-bit slave address
`define LDS_ADDR_FIXED 5'h00
`define LDS_SEL_RESET 2'h0
`define LDS_RW_READ 1'b1

// ****************************************************************
// serial framing and buffering
// ****************************************************************
`define LDS_LAST_BIT 3'h7
`define LDS_BIT_ZERO 3'h0
`define LDS_FIFO_DEPTH 32
`define LDS_FIFO_WIDTH 16
`define LDS_ARRAY_WORDS 32
// fastest serial clock the slave is built for, in kHz
`define LDS_SCL_MAX_KHZ 3400

`endif

// ==== pkg/lds_pkg.sv ====
package lds_pkg;

  // one-hot states of the serial engine
  typedef enum logic [9:0] {
    LDS_IDLE = 10'h001,
    LDS_ADDR = 10'h002,
    LDS_ADDR_ACK = 10'h004,
    LDS_CMD = 10'h008,
    LDS_CMD_ACK = 10'h010,
    LDS_WDATA = 10'h020,
    LDS_WDATA_ACK = 10'h040,
    LDS_RDATA = 10'h080,
    LDS_RDATA_ACK = 10'h100,
    LDS_IGNORE = 10'h200
  } lds_state_type;

  // one register write: command byte selects, data byte is stored
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } lds_wr_type;

  // filtered pin levels
  typedef struct packed {
    logic scl;
    logic sda;
    logic shutdown_n;
    logic seg_g;
    logic seg_f;
  } lds_pins_type;

endpackage

// ==== rtl/lds_slave.sv ====
`timescale 1ns/100ps
// Function
// - slave on two-wire bus, serial clock up to 3.4 MHz.
// - data stable while clock high; changes then are bus conditions.
// - START is data fall with clock high, STOP data rise with clock high.
// - bytes of eight bits, one per clock, ninth bit acknowledges.
// - addressed receiver holds data low through acknowledge clock high phase.
// - read ends by master not acknowledging; slave releases data line.
// - write takes address then any number of acknowledged data bytes; bytes are refused once a stalled core fills the buffer.
// - read drives successive data bytes clocked by master clock.
// - STOP or repeated START ends a transfer; repeated START begins new address.
// - seven address bits compared in hardware, direction bit latched; acknowledge only on match.
// - after startup answer to all-zero seven-bit address.
// - two lowest address bits are device select, set by self-address.
// - last address bit: one reads, zero writes.
// - self-address takes select bits from segment G and F straps.
// - one self-address command updates all devices; reissue after power loss.
// - command byte after address selects register, most significant bit first.
// - reset clears registers to defaults, blanks display, enters shutdown.
// - shutdown pin low writes shutdown; shutdown persists until serial write.
// - serial shutdown write enters shutdown; digit registers keep contents.
// - entering or leaving shutdown clears feature unless keep bit set.
// - bit zero selects normal operation, bit seven keeps feature register.
`include "lds_regs.svh"

// ****************************************************************
// three-stage input filter
// ****************************************************************
module lds_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] filt
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (srst)
      filt <= RST;
    else
      filt <= (s2_q & s3_q) | (filt & (s2_q | s3_q));
  end
endmodule // lds_sync

// ****************************************************************
// write buffer
// ****************************************************************
module lds_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // filling side
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  // draining side
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign s_ready = (wr_ptr_q[AW] == rd_ptr_q[AW]) || (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]);
  assign m_valid = wr_ptr_q != rd_ptr_q;
  assign m_data = mem[rd_ptr_q[AW-1:0]];
  assign push = s_valid && s_ready;
  assign pop = m_valid && m_ready;

  // storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q[AW-1:0]] <= s_data;
  end

  // pointers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule // lds_fifo

// ****************************************************************
// serial slave with shutdown control
// ****************************************************************
module lds_slave (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial bus, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // hardware shutdown pin and self-address straps
  input wire logic hardware_shutdown_pin_n,
  input wire logic segment_g_line,
  input wire logic segment_f_line,
  // register write stream to the display core
  output logic wr_valid,
  output lds_pkg::lds_wr_type wr_item,
  input wire logic wr_ready,
  // status
  output logic shutdown,
  output logic display_blank,
  output logic [7:0] feature,
  output logic [1:0] device_select
);
  lds_pkg::lds_pins_type pins;
  lds_pkg::lds_state_type state_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] rx_byte;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic ack_q;
  logic ack_ph_q;
  logic rw_q;
  logic addr_match;
  logic fifo_s_valid;
  logic fifo_s_ready;
  logic fifo_m_valid;
  logic fifo_m_ready;
  lds_pkg::lds_wr_type fifo_s_data;
  lds_pkg::lds_wr_type fifo_m_data;
  logic [7:0] sd_reg_q;
  logic [7:0] feature_q;
  logic [1:0] sel_q;
  logic [7:0] regs_q [`LDS_ARRAY_WORDS];
  logic [7:0] read_byte;
  logic apply;
  logic [7:0] sd_new;
  logic sd_write;

  // ****************************************************************
  // pin filtering and bus conditions
  // ****************************************************************
  // clock is sampled like data; at the top rate the filter delay eats most of the low phase
  lds_sync #(
    .W(5),
    .RST(5'h1f)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .raw({scl_in, sda_in, hardware_shutdown_pin_n, segment_g_line, segment_f_line}),
    .filt(pins)
  );

  // previous filtered levels for edge finding
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= pins.scl;
      sda_prev_q <= pins.sda;
    end
  end

  // data moving while clock is high is a condition, never a bit
  assign scl_rise = pins.scl && !scl_prev_q;
  assign scl_fall = !pins.scl && scl_prev_q;
  assign start_det = pins.scl && scl_prev_q && sda_prev_q && !pins.sda;
  assign stop_det = pins.scl && scl_prev_q && !sda_prev_q && pins.sda;

  // byte as it stands after the current rising edge
  assign rx_byte = {rx_q[6:0], pins.sda};
  // upper bits fixed at zero, low two from self-addressing
  assign addr_match = rx_byte[7:1] == {`LDS_ADDR_FIXED, sel_q};

  // ****************************************************************
  // serial engine
  // ****************************************************************
  // bits are taken on rising clock, acknowledge phases step on falling clock
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= lds_pkg::LDS_IDLE;
      bit_cnt_q <= `LDS_BIT_ZERO;
      rx_q <= '0;
      tx_q <= '0;
      ptr_q <= '0;
      ack_q <= 1'b0;
      ack_ph_q <= 1'b0;
      rw_q <= 1'b0;
    end
    else if (start_det)
    begin
      // a repeated start also lands here, bus stays owned
      state_q <= lds_pkg::LDS_ADDR;
      bit_cnt_q <= `LDS_BIT_ZERO;
      ack_ph_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= lds_pkg::LDS_IDLE;
    end
    else
    begin
      unique case (state_q)
        lds_pkg::LDS_IDLE, lds_pkg::LDS_IGNORE:
        begin
          bit_cnt_q <= `LDS_BIT_ZERO;
        end
        lds_pkg::LDS_ADDR, lds_pkg::LDS_CMD, lds_pkg::LDS_WDATA:
        begin
          if (scl_rise)
          begin
            // most significant bit first, eight clocks per byte
            rx_q <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == `LDS_LAST_BIT)
            begin
              ack_ph_q <= 1'b0;
              if (state_q == lds_pkg::LDS_ADDR)
              begin
                rw_q <= rx_byte[0] == `LDS_RW_READ;
                if (addr_match)
                begin
                  state_q <= lds_pkg::LDS_ADDR_ACK;
                  ack_q <= 1'b1;
                end
                else
                  state_q <= lds_pkg::LDS_IGNORE;
              end
              else if (state_q == lds_pkg::LDS_CMD)
              begin
                ptr_q <= rx_byte;
                state_q <= lds_pkg::LDS_CMD_ACK;
                ack_q <= 1'b1;
              end
              else
              begin
                // a full buffer refuses the byte with no acknowledge
                state_q <= lds_pkg::LDS_WDATA_ACK;
                ack_q <= fifo_s_ready;
              end
            end
          end
        end
        lds_pkg::LDS_ADDR_ACK, lds_pkg::LDS_CMD_ACK, lds_pkg::LDS_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            ack_ph_q <= !ack_ph_q;
            if (ack_ph_q)
            begin
              // end of the ninth clock
              bit_cnt_q <= `LDS_BIT_ZERO;
              if (!ack_q)
                state_q <= lds_pkg::LDS_IGNORE;
              else if (state_q == lds_pkg::LDS_ADDR_ACK && rw_q)
              begin
                state_q <= lds_pkg::LDS_RDATA;
                tx_q <= read_byte;
              end
              else if (state_q == lds_pkg::LDS_ADDR_ACK)
                state_q <= lds_pkg::LDS_CMD;
              else
                state_q <= lds_pkg::LDS_WDATA;
            end
          end
        end
        lds_pkg::LDS_RDATA:
        begin
          if (scl_rise)
          begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == `LDS_LAST_BIT)
            begin
              state_q <= lds_pkg::LDS_RDATA_ACK;
              ack_ph_q <= 1'b0;
            end
          end
          if (scl_fall)
            tx_q <= {tx_q[6:0], 1'b0};
        end
        lds_pkg::LDS_RDATA_ACK:
        begin
          if (scl_rise)
            ack_q <= !pins.sda;
          if (scl_fall)
          begin
            ack_ph_q <= !ack_ph_q;
            if (ack_ph_q)
            begin
              bit_cnt_q <= `LDS_BIT_ZERO;
              if (ack_q)
              begin
                state_q <= lds_pkg::LDS_RDATA;
                tx_q <= read_byte;
              end
              else
                state_q <= lds_pkg::LDS_IGNORE;
            end
          end
        end
        default:
        begin
          state_q <= lds_pkg::LDS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // data line drive
  // ****************************************************************
  // drive only low, and change the drive only while clock is low, except on a start or stop
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      sda_out <= 1'b0;
      if (start_det || stop_det)
        sda_oe_n <= 1'b1;
      else if ((state_q == lds_pkg::LDS_ADDR_ACK || state_q == lds_pkg::LDS_CMD_ACK ||
                state_q == lds_pkg::LDS_WDATA_ACK) && ack_ph_q)
        sda_oe_n <= !ack_q;
      // the last bit stands until its clock falls; releasing it earlier would look like a stop
      else if (state_q == lds_pkg::LDS_RDATA || (state_q == lds_pkg::LDS_RDATA_ACK && !ack_ph_q))
        sda_oe_n <= tx_q[7];
      else
        sda_oe_n <= 1'b1;
    end
  end

  // ****************************************************************
  // write buffering
  // ****************************************************************
  // one entry per data byte, all aimed at the current command
  assign fifo_s_valid = state_q == lds_pkg::LDS_WDATA && scl_rise && bit_cnt_q == `LDS_LAST_BIT &&
                        !start_det && !stop_det;
  assign fifo_s_data = '{cmd: ptr_q, data: rx_byte};

  lds_fifo #(
    .WIDTH(`LDS_FIFO_WIDTH),
    .DEPTH(`LDS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .s_valid(fifo_s_valid),
    .s_ready(fifo_s_ready),
    .s_data(fifo_s_data),
    .m_valid(fifo_m_valid),
    .m_ready(fifo_m_ready),
    .m_data(fifo_m_data)
  );

  // output stage; a stalled core fills the buffer and then bytes are refused
  assign fifo_m_ready = !wr_valid || wr_ready;
  assign apply = fifo_m_valid && fifo_m_ready;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_valid <= 1'b0;
      wr_item <= '0;
    end
    else if (fifo_m_ready)
    begin
      wr_valid <= fifo_m_valid;
      // an empty buffer shows unwritten storage, so keep the last item instead
      if (fifo_m_valid)
        wr_item <= fifo_m_data;
    end
  end

  // ****************************************************************
  // local registers
  // ****************************************************************
  // pin low acts as a shutdown write each cycle and wins over a serial one
  assign sd_write = !pins.shutdown_n || (apply && fifo_m_data.cmd == `LDS_CMD_SHUTDOWN);
  assign sd_new = !pins.shutdown_n ? `LDS_SD_PIN_CODE : fifo_m_data.data;

  // shutdown register; reset leaves the device shut down
  always_ff @(posedge clk)
  begin
    if (srst)
      sd_reg_q <= `LDS_SD_RESET;
    else if (sd_write)
      sd_reg_q <= sd_new;
  end

  // feature register cleared on a mode change unless the keep bit is set
  always_ff @(posedge clk)
  begin
    if (srst)
      feature_q <= `LDS_FEATURE_RESET;
    else if (sd_write && (sd_new[`LDS_NORMAL_OPERATION_BIT] != sd_reg_q[`LDS_NORMAL_OPERATION_BIT]) &&
             !sd_new[`LDS_KEEP_FEATURE_BIT])
      feature_q <= `LDS_FEATURE_RESET;
    else if (apply && fifo_m_data.cmd == `LDS_CMD_FEATURE)
      feature_q <= fifo_m_data.data;
  end

  // straps read straight from the filter, no key debounce in the path
  always_ff @(posedge clk)
  begin
    if (srst)
      sel_q <= `LDS_SEL_RESET;
    else if (apply && fifo_m_data.cmd == `LDS_CMD_SELF_ADDR)
      sel_q <= {pins.seg_f, pins.seg_g};
  end

  // mirror of the remaining registers; shutdown never touches digit contents
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < `LDS_ARRAY_WORDS; i++)
        regs_q[i] <= `LDS_REG_RESET;
    end
    else if (apply && fifo_m_data.cmd[`LDS_CMD_PAGE_MSB:`LDS_CMD_PAGE_LSB] == `LDS_CMD_PAGE_ZERO &&
             fifo_m_data.cmd != `LDS_CMD_SHUTDOWN && fifo_m_data.cmd != `LDS_CMD_FEATURE)
      regs_q[fifo_m_data.cmd[`LDS_CMD_IDX_MSB:0]] <= fifo_m_data.data;
  end

  // read source follows the last command byte; unmapped pages read zero
  always_comb
  begin
    if (ptr_q == `LDS_CMD_SHUTDOWN)
      read_byte = sd_reg_q;
    else if (ptr_q == `LDS_CMD_FEATURE)
      read_byte = feature_q;
    else if (ptr_q[`LDS_CMD_PAGE_MSB:`LDS_CMD_PAGE_LSB] == `LDS_CMD_PAGE_ZERO)
      read_byte = regs_q[ptr_q[`LDS_CMD_IDX_MSB:0]];
    else
      read_byte = `LDS_REG_RESET;
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  // display is blank whenever shut down
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shutdown <= 1'b1;
      display_blank <= 1'b1;
      feature <= `LDS_FEATURE_RESET;
      device_select <= `LDS_SEL_RESET;
    end
    else
    begin
      shutdown <= !sd_reg_q[`LDS_NORMAL_OPERATION_BIT];
      display_blank <= !sd_reg_q[`LDS_NORMAL_OPERATION_BIT];
      feature <= feature_q;
      device_select <= sel_q;
    end
  end
endmodule // lds_slave

// ==== rtl/lds_dummy_unused_guard.sv ====
`timescale 1ns/100ps

// ==== dv/lds_slave_asserts.sv ====
`timescale 1ns/100ps
`include "lds_regs.svh"
// ********************
// serial slave checker
// ********************
module lds_slave_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial bus and pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic hardware_shutdown_pin_n,
  input wire logic segment_g_line,
  input wire logic segment_f_line,
  // stream and status
  input wire logic wr_valid,
  input wire lds_pkg::lds_wr_type wr_item,
  input wire logic wr_ready,
  input wire logic shutdown,
  input wire logic display_blank,
  input wire logic [7:0] feature,
  input wire logic [1:0] device_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // normal-operation shutdown write sitting in the output stage
  logic leave_item;
  assign leave_item = wr_valid && wr_item.cmd == `LDS_CMD_SHUTDOWN && wr_item.data[0];
  // acknowledge held low across clock high
  sequence s_ack_hold;
    !sda_oe_n throughout (scl_in [*4]);
  endsequence
  // pin held low long enough to pass the filter
  sequence s_pin_low;
    !hardware_shutdown_pin_n [*3];
  endsequence
  a_reset_defaults:
  assert property (disable iff (1'b0) srst |=> shutdown && feature == 8'h00 && device_select == 2'h0 && sda_oe_n)
    else $error("reset state wrong");
  a_blank_shutdown:
  assert property (display_blank == shutdown)
    else $error("blank differs from shutdown");
  a_pin_enters:
  assert property (s_pin_low |-> ##[0:6] shutdown)
    else $error("pin low left device running");
  a_leave_cause:
  assert property ($fell(shutdown) |-> leave_item || $past(leave_item))
    else $error("shutdown left without normal write");
  a_stream_hold:
  assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_item))
    else $error("stream item lost before taken");
  a_open_drain:
  assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_data_clk_low:
  assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
    else $error("data changed while clock high");
  a_ack_stands:
  assert property ($rose(scl_in) && !sda_oe_n |-> s_ack_hold)
    else $error("low data released in clock high");
  a_select_cause:
  assert property ($changed(device_select) |->
    wr_item.cmd == `LDS_CMD_SELF_ADDR || $past(wr_item.cmd) == `LDS_CMD_SELF_ADDR)
    else $error("select changed without command");
  a_feature_cause:
  assert property ($changed(feature) && feature != 8'h00 |->
    wr_item.cmd == `LDS_CMD_FEATURE || $past(wr_item.cmd) == `LDS_CMD_FEATURE)
    else $error("feature set without feature write");
endmodule // lds_slave_asserts

bind lds_slave lds_slave_asserts u_chk (.clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hardware_shutdown_pin_n(hardware_shutdown_pin_n),
  .segment_g_line(segment_g_line), .segment_f_line(segment_f_line), .wr_valid(wr_valid),
  .wr_item(wr_item), .wr_ready(wr_ready), .shutdown(shutdown), .display_blank(display_blank),
  .feature(feature), .device_select(device_select));

// ==== dv/lds_master_model.sv ====
`timescale 1ns/100ps
// ********************
// bus master model
// ********************
module lds_master_model #(
  parameter int T = 160
) (
  // alignment clock
  input wire logic clk,
  // bus, sda_drv high releases data
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // idle bus, both lines high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // slots stretched so the slave's filter lag fits the low phase
  task automatic start();
    @(negedge clk);
    sda_drv = 1'b1;
    #T scl = 1'b1;
    #(2 * T) sda_drv = 1'b0;
    #(2 * T) scl = 1'b0;
  endtask
  task automatic stop();
    #T sda_drv = 1'b0;
    #T scl = 1'b1;
    #(2 * T) sda_drv = 1'b1;
    #(2 * T);
  endtask
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    #T sda_drv = b;
    #T scl = 1'b1;
    #T r = sda;
    #T scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // last byte of a read goes unacknowledged
  task automatic recv(input logic last, output logic [7:0] b, output logic rel);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, rel);
  endtask
endmodule // lds_master_model

// ==== dv/lds_slave_tb.sv ====
`timescale 1ns/100ps
`include "lds_regs.svh"
// ********************
// serial slave bench
// ********************
module lds_slave_tb;
  logic clk, srst, scl, sda_m, sda_oe_n, sda_out, wr_valid, wr_ready, shutdown, display_blank, ack, rel;
  logic hardware_shutdown_pin_n, segment_g_line, segment_f_line;
  logic [7:0] feature, rd;
  logic [1:0] device_select;
  logic [2:0] k;
  logic [6:0] dev;
  logic [7:0] codes [4] = '{8'h81, 8'h80, 8'h01, 8'h00};
  lds_pkg::lds_wr_type wr_item;
  lds_pkg::lds_wr_type got[$];
  int failures, n_tests, cycles, n;
  wire sda;
  // pulled-up open drain data line
  assign sda = sda_m & (sda_oe_n | sda_out);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  lds_slave uut (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .hardware_shutdown_pin_n(hardware_shutdown_pin_n), .segment_g_line(segment_g_line),
    .segment_f_line(segment_f_line), .wr_valid(wr_valid), .wr_item(wr_item), .wr_ready(wr_ready),
    .shutdown(shutdown), .display_blank(display_blank), .feature(feature), .device_select(device_select));
  lds_master_model mst (.clk(clk), .scl(scl), .sda_drv(sda_m), .sda(sda));
  // collect taken items, cut a hang short
  always @(posedge clk)
  begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      got.push_back(wr_item);
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic check(input logic [15:0] a, input logic [15:0] e, input string m);
    n_tests++;
    if (a !== e)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, a, e);
    end
  endtask
  // address, command, data; k holds the three acknowledges
  task automatic write_reg(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic [2:0] r);
    mst.start();
    mst.send({a, 1'b0}, r[2]);
    mst.send(c, r[1]);
    mst.send(d, r[0]);
    mst.stop();
  endtask
  // pointer write, repeated start, two bytes read
  task automatic read_check(input logic [7:0] c, input logic [7:0] e);
    mst.start();
    mst.send({dev, 1'b0}, ack);
    mst.send(c, ack);
    mst.start();
    mst.send({dev, 1'b1}, ack);
    check(ack, 1'b1, "read address ack");
    mst.recv(1'b0, rd, rel);
    check(rd, e, "first read byte");
    mst.recv(1'b1, rd, rel);
    check(rd, e, "last read byte");
    check(rel, 1'b1, "line released");
    mst.stop();
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    srst = 1'b1;
    hardware_shutdown_pin_n = 1'b1;
    segment_g_line = 1'b1;
    segment_f_line = 1'b0;
    wr_ready = 1'b1;
    dev = 7'h00;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    check(shutdown, 1'b1, "reset shutdown");
    check(feature, 8'h00, "reset feature");
    write_reg(7'h04, 8'h01, 8'h11, k);
    check(k, 3'b000, "foreign address");
    write_reg(7'h01, 8'h01, 8'h11, k);
    check(k, 3'b000, "select unset");
    write_reg(dev, 8'h01, 8'ha5, k);
    check(k, 3'b111, "write acks");
    check(16'(got.size()), 16'h0001, "item count");
    check(got[0], 16'h01a5, "item");
    // every shutdown code, feature preset each time
    foreach (codes[i])
    begin
      write_reg(dev, `LDS_CMD_FEATURE, 8'h55, k);
      write_reg(dev, `LDS_CMD_SHUTDOWN, codes[i], k);
      check(shutdown, !codes[i][0], "shutdown code");
      check(feature, codes[i][7] ? 8'h55 : 8'h00, "feature keep");
    end
    write_reg(dev, `LDS_CMD_SHUTDOWN, 8'h81, k);
    write_reg(dev, `LDS_CMD_FEATURE, 8'h55, k);
    hardware_shutdown_pin_n = 1'b0;
    repeat (20) @(negedge clk);
    check(shutdown, 1'b1, "pin shutdown");
    check(feature, 8'h00, "pin clears feature");
    hardware_shutdown_pin_n = 1'b1;
    repeat (20) @(negedge clk);
    check(shutdown, 1'b1, "shutdown persists");
    read_check(8'h01, 8'ha5);
    write_reg(dev, `LDS_CMD_SELF_ADDR, 8'h00, k);
    check(device_select, 2'h1, "select bits");
    write_reg(7'h00, 8'h02, 8'h3c, k);
    check(k, 3'b000, "old address");
    dev = 7'h01;
    write_reg(dev, 8'h02, 8'h3c, k);
    check(k, 3'b111, "new address");
    read_check(8'h02, 8'h3c);
    // fill the buffer with the core stalled until a byte is refused
    wr_ready = 1'b0;
    got.delete();
    mst.start();
    mst.send({dev, 1'b0}, ack);
    mst.send(8'h03, ack);
    n = 0;
    while (ack && n < 40)
    begin
      mst.send(n[7:0], ack);
      if (ack)
        n++;
    end
    mst.stop();
    check(16'(n >= 32 && n < 40), 16'h0001, "buffer refusal");
    wr_ready = 1'b1;
    repeat (100) @(negedge clk);
    check(16'(got.size()), 16'(n), "drained count");
    for (int i = 0; i < n; i++)
      check(got[i], {8'h03, i[7:0]}, "drained item");
    close_out();
  end
endmodule // lds_slave_tb
